// ==== bench/flan_chk.sv ====
// Port checker for the negotiation core.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

module flan_chk #(
    parameter int LINK_TIMER_CYCLES = 20,
    parameter logic [15:0] POSSESS_MASK = 16'h81e0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] tx_cfg_word,
    input wire logic tx_send_cfg,
    input wire logic [15:0] adv_ability,
    input wire logic [1:0] rf_request,
    input wire logic exp_read,
    input wire logic [15:0] mr_status,
    input wire logic [15:0] mr_partner_base,
    input wire logic [15:0] mr_expansion,
    input wire logic [15:0] mr_partner_nxt,
    input wire logic [15:0] mr_ext_status,
    input wire flan_pkg::flan_res_t resolved
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    localparam int MIN_IDLE = LINK_TIMER_CYCLES - 2; // Slack for output lag
    logic rf_seen_q; // A fault code may still be latched
    logic send_q; // Last send level
    int idle_q; // Cycles since sending stopped

    // Shadow of the fault latch; kept set while in doubt
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rf_seen_q <= 1'b0;
            send_q <= 1'b0;
            idle_q <= 0;
        end
        else
        begin
            send_q <= tx_send_cfg;
            if (rf_request != 2'h0)
                rf_seen_q <= 1'b1;
            else if (send_q && !tx_send_cfg)
                rf_seen_q <= 1'b0;
            idle_q <= tx_send_cfg ? 0 : idle_q + 1;
        end
    end

    AST_RES_ZERO: assert property (
        tx_send_cfg && !adv_ability[15] |-> (tx_cfg_word & 16'h0e1f) == 16'h0000)
        else $error("reserved word bits set");
    AST_OWN_ABILITY: assert property (
        tx_send_cfg && !adv_ability[15]
        |-> (tx_cfg_word[8:5] & ~(adv_ability[8:5] & POSSESS_MASK[8:5])) == 4'h0)
        else $error("foreign ability sent");
    AST_RF_ZERO: assert property (
        tx_send_cfg && !adv_ability[15] && !rf_seen_q |-> tx_cfg_word[13:12] == 2'h0)
        else $error("fault field not zero");
    AST_RF_STATUS: assert property (
        $changed(mr_partner_base) && mr_partner_base[13:12] != 2'h0 |-> ##[0:2] mr_status[4])
        else $error("fault status not set");
    AST_PAGE_CLEAR: assert property (
        exp_read && $stable(mr_partner_base) && $stable(mr_partner_nxt) |=> !mr_expansion[1])
        else $error("page flag kept after read");
    AST_FIXED_BITS: assert property (
        mr_status[0] && mr_status[3]
        && mr_ext_status[15:14] == {POSSESS_MASK[5], POSSESS_MASK[6]})
        else $error("fixed status bits wrong");
    AST_FULL_WINS: assert property (
        $rose(mr_status[5]) && &(adv_ability[6:5] & mr_partner_base[6:5] & POSSESS_MASK[6:5])
        |-> resolved.full_duplex && !resolved.half_duplex)
        else $error("half duplex chosen");
    AST_SYM_PAUSE: assert property (
        $rose(mr_status[5]) && adv_ability[7] && POSSESS_MASK[7] && mr_partner_base[7]
        |-> resolved.tx_pause && resolved.rx_pause)
        else $error("pause not symmetric");
    AST_NXT_HOLD: assert property (
        $rose(mr_expansion[1]) |-> ##2 $stable(tx_cfg_word[15]) [*8])
        else $error("next page flag moved early");
    AST_SETTLE: assert property (
        $rose(mr_status[2]) |-> idle_q >= MIN_IDLE)
        else $error("link up before settle time");
endmodule

bind flan_core flan_chk #(
    .LINK_TIMER_CYCLES(LINK_TIMER_CYCLES),
    .POSSESS_MASK(POSSESS_MASK)
) u_chk (
    .clk(clk), .resetn(resetn), .tx_cfg_word(tx_cfg_word), .tx_send_cfg(tx_send_cfg),
    .adv_ability(adv_ability), .rf_request(rf_request), .exp_read(exp_read),
    .mr_status(mr_status), .mr_partner_base(mr_partner_base), .mr_expansion(mr_expansion),
    .mr_partner_nxt(mr_partner_nxt), .mr_ext_status(mr_ext_status), .resolved(resolved)
);

`default_nettype wire

// ==== bench/flan_partner.sv ====
// Remote negotiation logic across the link.
// Assumes it shares clk with the core and reacts to the core's word.
`default_nettype none

module flan_partner (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] lp_base,
    input wire logic slow,
    input wire logic [15:0] tx_cfg_word,
    input wire logic tx_send_cfg,
    output logic rx_cfg_valid,
    output logic [15:0] rx_cfg_word,
    output logic rx_idle_valid
);
    logic [1:0] gap_q; // Set spacing when slow
    logic [15:0] word; // Word sent now

    // Base page, or a null page answering a core next page
    always_comb
    begin
        if (lp_base[15] && tx_cfg_word[13])
            word = 16'h2801;
        else
            word = lp_base;
        word[14] = (tx_cfg_word != 16'h0000); // Ack once the core speaks
    end

    // One set per cycle, or per third cycle when slow
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            gap_q <= 2'h0;
            rx_cfg_valid <= 1'b0;
            rx_idle_valid <= 1'b0;
            rx_cfg_word <= 16'h0000;
        end
        else
        begin
            gap_q <= (slow && gap_q != 2'h2) ? gap_q + 2'h1 : 2'h0;
            rx_cfg_valid <= tx_send_cfg && gap_q == 2'h0;
            rx_idle_valid <= !tx_send_cfg && gap_q == 2'h0;
            // Gaps carry a changing pattern, the last word's inverse and the last word in turn
            rx_cfg_word <= (tx_send_cfg && gap_q == 2'h0) ? word : ~rx_cfg_word;
        end
    end
endmodule

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench: negotiation core against the partner model.
// Assumes a 100 MHz clock; inputs move on falling edges.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LT = 20; // Short settle timer
    localparam logic [15:0] ADV_T [4] = '{16'h01e0, 16'h0160, 16'h01e0, 16'h0060};
    localparam logic [15:0] LP_T [4] = '{16'h00e0, 16'h01e0, 16'h0160, 16'h0040};
    localparam logic [4:0] RES_T [4] = '{5'h16, 5'h14, 5'h12, 5'h08};
    logic clk, resetn, an_enable, an_restart, nxt_tx_load, status_read, exp_read, slow;
    logic [15:0] adv_ability, nxt_tx_word, lp_base, rx_cfg_word, tx_cfg_word, mr_status;
    logic [15:0] mr_partner_base, mr_expansion, mr_nxt_tx, mr_partner_nxt, mr_ext_status;
    logic [1:0] rf_request;
    logic rx_cfg_valid, rx_idle_valid, tx_send_cfg;
    flan_pkg::flan_res_t resolved;
    int n_errors = 0;
    int num_checks = 0;

    flan_core #(.LINK_TIMER_CYCLES(LT)) dut (
        .clk(clk), .resetn(resetn), .rx_cfg_valid(rx_cfg_valid), .rx_cfg_word(rx_cfg_word),
        .rx_idle_valid(rx_idle_valid), .tx_cfg_word(tx_cfg_word), .tx_send_cfg(tx_send_cfg),
        .an_enable(an_enable), .an_restart(an_restart), .adv_ability(adv_ability),
        .rf_request(rf_request), .nxt_tx_word(nxt_tx_word), .nxt_tx_load(nxt_tx_load),
        .status_read(status_read), .exp_read(exp_read), .mr_status(mr_status),
        .mr_partner_base(mr_partner_base), .mr_expansion(mr_expansion), .mr_nxt_tx(mr_nxt_tx),
        .mr_partner_nxt(mr_partner_nxt), .mr_ext_status(mr_ext_status), .resolved(resolved));
    flan_partner u_peer (
        .clk(clk), .resetn(resetn), .lp_base(lp_base), .slow(slow), .tx_cfg_word(tx_cfg_word),
        .tx_send_cfg(tx_send_cfg), .rx_cfg_valid(rx_cfg_valid), .rx_cfg_word(rx_cfg_word),
        .rx_idle_valid(rx_idle_valid));

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // A wait that ran out ends the run
    task automatic give_up(input string nm);
        n_errors++;
        $display("unexpected %s: expected event seen timeout", nm);
        summarize();
    endtask

    // Bounded wait for a sent word matching a mask
    task automatic wait_tx(input logic [15:0] m, input logic [15:0] v);
        for (int i = 0; i < 600; i++)
        begin
            @(negedge clk);
            if (tx_send_cfg === 1'b1 && (tx_cfg_word & m) === v)
                return;
        end
        give_up("sent word");
    endtask

    task automatic wait_link();
        for (int i = 0; i < 600; i++)
        begin
            @(negedge clk);
            if (mr_status[2] === 1'b1)
                return;
        end
        give_up("link up");
    endtask

    // Restart with new local and partner pages
    task automatic negotiate(input logic [15:0] adv, input logic [15:0] lp);
        @(negedge clk);
        adv_ability = adv;
        lp_base = lp;
        an_restart = 1'b1;
        @(negedge clk) an_restart = 1'b0;
        @(negedge clk);
    endtask

    task automatic t_reset_values();
        chk("status", 16'h0009, mr_status);
        chk("send", 16'h0000, {15'h0000, tx_send_cfg});
        chk("next able", 16'h0004, mr_expansion & 16'h0004);
        chk("ext status", 16'hc000, mr_ext_status & 16'hc000);
    endtask

    task automatic t_resolution();
        for (int i = 0; i < 4; i++)
        begin
            slow = i[0];
            negotiate(ADV_T[i], LP_T[i]);
            wait_link();
            chk("status", 16'h0024, mr_status & 16'h0024);
            chk("resolved", {11'h000, RES_T[i]}, {11'h000, resolved});
            chk("partner base", LP_T[i] | 16'h4000, mr_partner_base);
            chk("page rx", 16'h0002, mr_expansion & 16'h0002);
            @(negedge clk) exp_read = 1'b1;
            @(negedge clk) exp_read = 1'b0;
            chk("page rx", 16'h0000, mr_expansion & 16'h0002);
        end
        slow = 1'b0;
    endtask

    task automatic t_remote_fault();
        for (int c = 1; c < 4; c++)
        begin
            rf_request = c[1:0];
            slow = (c == 2);
            negotiate(16'h0020, {2'h0, c[1:0], 12'h020});
            wait_tx(16'h4000, 16'h4000);
            chk("fault sent", {14'h0, c[1:0]}, {14'h0, tx_cfg_word[13:12]});
            rf_request = 2'h0;
            wait_link();
            chk("fault status", 16'h0010, mr_status & 16'h0010);
            @(negedge clk) status_read = 1'b1;
            @(negedge clk) status_read = 1'b0;
            chk("fault status", 16'h0000, mr_status & 16'h0010);
        end
        slow = 1'b0;
    endtask

    // Reserved message code, then a partner with and without pages
    task automatic t_next_page();
        nxt_tx_word = 16'h27ff;
        nxt_tx_load = 1'b1;
        @(negedge clk) nxt_tx_load = 1'b0;
        chk("next tx", 16'h27ff, mr_nxt_tx);
        negotiate(16'h81e0, 16'h00e0);
        wait_tx(16'h8000, 16'h8000);
        wait_link();
        chk("partner next", 16'h0000, mr_partner_nxt);
        negotiate(16'h81e0, 16'h80e0);
        wait_tx(16'h2000, 16'h2000);
        chk("page sent", 16'h2001, tx_cfg_word & 16'ha7ff);
        wait_link();
        chk("partner next", 16'h2801, mr_partner_nxt & 16'hbfff);
    endtask

    // Main sequence
    initial
    begin
        {an_enable, an_restart, nxt_tx_load, status_read, exp_read, slow} = 6'h00;
        resetn = 1'b0;
        adv_ability = 16'h0000;
        nxt_tx_word = 16'h0000;
        lp_base = 16'h0000;
        rf_request = 2'h0;
        repeat (12) @(negedge clk);
        t_reset_values();
        resetn = 1'b1;
        an_enable = 1'b1;
        t_resolution();
        t_remote_fault();
        t_next_page();
        summarize();
    end
endmodule

`default_nettype wire

// ==== verilog/flan_core.sv ====
// Auto-negotiation core of a gigabit fibre link endpoint: builds and
// exchanges the 16-bit configuration word, resolves duplex and pause,
// runs the next-page exchange and holds the management equivalents.
// Assumes the coding sublayer on the same clock reports each received
// /C/ word and each /I/ as one-cycle pulses, and sends tx_cfg_word as
// /C/ while tx_send_cfg is high, idles otherwise.
`default_nettype none
`include "flan_defs.svh"

module flan_core #(
    parameter int LINK_TIMER_CYCLES = `FLAN_LINK_TIMER_MS * `FLAN_CLK_KHZ,
    parameter logic [15:0] POSSESS_MASK = 16'h81e0,
    parameter logic USE_MGMT = 1'b1,
    parameter logic [15:0] FIXED_ADV = 16'h0020,
    parameter logic NXT_ABLE = 1'b1,
    parameter logic [10:0] MSG_CODE_MAX = `FLAN_MSG_MAX
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_cfg_valid,
    input wire logic [15:0] rx_cfg_word,
    input wire logic rx_idle_valid,
    output logic [15:0] tx_cfg_word,
    output logic tx_send_cfg,
    input wire logic an_enable,
    input wire logic an_restart,
    input wire logic [15:0] adv_ability,
    input wire logic [1:0] rf_request,
    input wire logic [15:0] nxt_tx_word,
    input wire logic nxt_tx_load,
    input wire logic status_read,
    input wire logic exp_read,
    output logic [15:0] mr_status,
    output logic [15:0] mr_partner_base,
    output logic [15:0] mr_expansion,
    output logic [15:0] mr_nxt_tx,
    output logic [15:0] mr_partner_nxt,
    output logic [15:0] mr_ext_status,
    output flan_pkg::flan_res_t resolved
);
    flan_pkg::flan_core_t q; // Registered state
    flan_pkg::flan_core_t d; // Next state
    logic tmr_start; // Restart settle timer
    logic tmr_done; // Settle timer expired
    logic abil_match; // Three equal /C/ words
    logic ack_match; // Three equal words with ack set
    logic idle_match; // Three /I/ in a row
    logic go_restart; // Enter restart this cycle
    logic [15:0] adv_eff; // Ability actually offered
    logic [15:0] base_page; // Base page without ack or fault
    logic [1:0] rf_send; // Fault code for a new restart
    logic lp_null; // Received page is a null message

    // Settle timer shared by restart, acknowledge-complete and idle wait
    flan_timer #(
        .CYCLES(LINK_TIMER_CYCLES)
    ) u_timer (
        .clk(clk),
        .resetn(resetn),
        .start(tmr_start),
        .done(tmr_done)
    );

    // Build one next page; a missing page becomes a null message page
    function automatic logic [15:0] nxt_page(input logic [15:0] w, input logic valid,
                                            input logic tgl);
        logic [15:0] p;
        p = w;
        if (!valid)
        begin
            p = 16'h0000;
            p[`FLAN_BIT_MSG] = 1'b1;
            p[10:0] = `FLAN_MSG_NULL;
        end
        else if (p[`FLAN_BIT_MSG] && (p[10:0] == 11'h000 || p[10:0] > MSG_CODE_MAX))
        begin
            // Reserved code replaced, not sent
            p[10:0] = `FLAN_MSG_NULL;
        end
        p[`FLAN_BIT_ACK] = 1'b0; // Ack added per state
        p[`FLAN_BIT_TGL] = tgl;
        return p;
    endfunction

    // Offered abilities: never more than the hardware has
    always_comb
    begin
        adv_eff = (USE_MGMT ? adv_ability : FIXED_ADV) & POSSESS_MASK;
        adv_eff = adv_eff & `FLAN_ABIL_MASK;
        if (!NXT_ABLE)
            adv_eff[`FLAN_BIT_NXT] = 1'b0;
        base_page = adv_eff;
        rf_send = (q.rf_hold != `FLAN_RF_NONE) ? q.rf_hold : rf_request;
    end

    // Match detectors on the latched receive history
    always_comb
    begin
        abil_match = (q.cnt == 2'h3);
        ack_match = abil_match && q.last_rx[`FLAN_BIT_ACK];
        idle_match = (q.idle_cnt == 2'h3);
        lp_null = q.last_rx[`FLAN_BIT_MSG] && (q.last_rx[10:0] == `FLAN_MSG_NULL);
    end

    // Next-state logic
    always_comb
    begin
        d = q;
        tmr_start = 1'b0;
        go_restart = 1'b0;
        d.an_en_prev = an_enable;

        // Count consecutive equal /C/ words and consecutive /I/
        if (rx_cfg_valid)
        begin
            d.idle_cnt = 2'h0;
            d.last_rx = rx_cfg_word;
            if (q.cnt != 2'h0 && rx_cfg_word == q.last_rx)
                d.cnt = (q.cnt == 2'h3) ? 2'h3 : q.cnt + 2'h1;
            else
                d.cnt = 2'h1;
        end
        else if (rx_idle_valid)
        begin
            d.cnt = 2'h0;
            d.idle_cnt = (q.idle_cnt == 2'h3) ? 2'h3 : q.idle_cnt + 2'h1;
        end

        // Software clears first so a same-cycle set survives
        if (exp_read)
            d.page_rx = 1'b0;
        if (status_read)
            d.rf_status = 1'b0;
        if (nxt_tx_load)
        begin
            d.nxt_tx = nxt_tx_word;
            d.nxt_tx_valid = 1'b1;
        end
        // Latch a requested fault so it cannot vanish mid-exchange
        if (q.rf_hold == `FLAN_RF_NONE && rf_request != `FLAN_RF_NONE)
            d.rf_hold = rf_request;

        case (q.state)
            flan_pkg::FLAN_AN_ENABLE:
            begin
                if (an_enable)
                    go_restart = 1'b1;
            end
            flan_pkg::FLAN_AN_RESTART:
            begin
                if (tmr_done)
                    d.state = flan_pkg::FLAN_ABIL_DETECT;
            end
            flan_pkg::FLAN_ABIL_DETECT, flan_pkg::FLAN_NXT_WAIT:
            begin
                if (abil_match && q.last_rx != 16'h0000)
                begin
                    d.abil_word = q.last_rx;
                    d.state = flan_pkg::FLAN_ACK_DETECT;
                end
            end
            flan_pkg::FLAN_ACK_DETECT:
            begin
                if (abil_match && q.last_rx == 16'h0000)
                    d.state = flan_pkg::FLAN_AN_ENABLE; // Partner restarted
                else if (ack_match)
                begin
                    // Acked word must agree with the word first matched
                    if ({q.last_rx[15], q.last_rx[13:0]} == {q.abil_word[15], q.abil_word[13:0]})
                    begin
                        d.state = flan_pkg::FLAN_COMPLETE_ACK;
                        tmr_start = 1'b1;
                        d.page_rx = 1'b1;
                        d.lp_more = q.last_rx[`FLAN_BIT_NXT] &&
                                    !(q.nxt_phase && lp_null);
                        if (!q.nxt_phase)
                        begin
                            d.lp_base = q.last_rx;
                            if (q.last_rx[13:12] != `FLAN_RF_NONE)
                                d.rf_status = 1'b1;
                        end
                        else
                        begin
                            d.lp_nxt = q.last_rx;
                        end
                    end
                    else
                    begin
                        d.state = flan_pkg::FLAN_AN_ENABLE;
                    end
                end
            end
            flan_pkg::FLAN_COMPLETE_ACK:
            begin
                // Word stays unchanged until the settle timer runs out
                if (tmr_done)
                begin
                    if (q.base_word[`FLAN_BIT_NXT] && q.lp_base[`FLAN_BIT_NXT] &&
                        (q.page_word[`FLAN_BIT_NXT] || q.lp_more))
                    begin
                        d.state = flan_pkg::FLAN_NXT_WAIT;
                        d.nxt_phase = 1'b1;
                        d.tgl = ~q.tgl;
                        d.page_word = nxt_page(q.nxt_tx, q.nxt_tx_valid, ~q.tgl);
                        d.nxt_tx_valid = nxt_tx_load; // Consumed unless refilled
                    end
                    else
                    begin
                        d.state = flan_pkg::FLAN_IDLE_DETECT;
                        tmr_start = 1'b1;
                        d.rf_hold = `FLAN_RF_NONE;
                    end
                end
            end
            flan_pkg::FLAN_IDLE_DETECT:
            begin
                if (tmr_done && idle_match)
                begin
                    d.state = flan_pkg::FLAN_LINK_OK;
                    d.an_complete = 1'b1;
                    // Duplex: full preferred when both offer it
                    d.res.full_duplex = q.base_word[`FLAN_BIT_FD] &&
                                        q.lp_base[`FLAN_BIT_FD];
                    d.res.half_duplex = !d.res.full_duplex &&
                                        q.base_word[`FLAN_BIT_HD] && q.lp_base[`FLAN_BIT_HD];
                    d.res.fail = !d.res.full_duplex && !d.res.half_duplex;
                    // Symmetric and asymmetric pause resolution
                    d.res.tx_pause = (q.base_word[`FLAN_BIT_PS1] && q.lp_base[`FLAN_BIT_PS1]) ||
                        (!q.base_word[`FLAN_BIT_PS1] && q.base_word[`FLAN_BIT_PS2] &&
                         q.lp_base[`FLAN_BIT_PS1] && q.lp_base[`FLAN_BIT_PS2]);
                    d.res.rx_pause = (q.base_word[`FLAN_BIT_PS1] && q.lp_base[`FLAN_BIT_PS1]) ||
                        (q.base_word[`FLAN_BIT_PS1] && q.base_word[`FLAN_BIT_PS2] &&
                         !q.lp_base[`FLAN_BIT_PS1] && q.lp_base[`FLAN_BIT_PS2]);
                end
                else if (abil_match)
                begin
                    d.state = flan_pkg::FLAN_AN_ENABLE; // Partner still configuring
                end
            end
            flan_pkg::FLAN_LINK_OK:
            begin
                if (abil_match)
                    go_restart = 1'b1; // Partner renegotiates
            end
            default:
            begin
                d.state = flan_pkg::FLAN_AN_ENABLE;
            end
        endcase

        // Restart request or enable change overrides any state
        if (an_enable && (an_restart || !q.an_en_prev))
            go_restart = 1'b1;
        if (!an_enable)
        begin
            go_restart = 1'b0;
            d.state = flan_pkg::FLAN_AN_ENABLE;
        end
        if (go_restart)
        begin
            d.state = flan_pkg::FLAN_AN_RESTART;
            tmr_start = 1'b1;
            d.nxt_phase = 1'b0;
            d.tgl = 1'b0;
            d.base_word = base_page;
            d.page_word = base_page | {2'h0, rf_send, 12'h000};
        end
        if (d.state != q.state && d.state != flan_pkg::FLAN_LINK_OK)
            d.an_complete = 1'b0;
        // Matches evaluate fresh on each state entry
        if (d.state != q.state)
        begin
            d.cnt = 2'h0;
            d.idle_cnt = 2'h0;
        end

        // Transmitted word follows the state being entered
        case (d.state)
            flan_pkg::FLAN_ABIL_DETECT, flan_pkg::FLAN_NXT_WAIT:
            begin
                d.tx_word = d.page_word;
                d.send_cfg = 1'b1;
            end
            flan_pkg::FLAN_ACK_DETECT, flan_pkg::FLAN_COMPLETE_ACK:
            begin
                d.tx_word = d.page_word | 16'h4000;
                d.send_cfg = 1'b1;
            end
            flan_pkg::FLAN_AN_RESTART:
            begin
                d.tx_word = 16'h0000; // Zero word forces partner restart
                d.send_cfg = 1'b1;
            end
            default:
            begin
                d.tx_word = 16'h0000;
                d.send_cfg = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.state <= flan_pkg::FLAN_AN_ENABLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Management equivalents, assembled from registered state
    always_comb
    begin
        mr_status = 16'h0000;
        mr_status[`FLAN_ST_EXT_CAP] = 1'b1;
        mr_status[`FLAN_ST_LINK] = (q.state == flan_pkg::FLAN_LINK_OK);
        mr_status[`FLAN_ST_AN_ABLE] = 1'b1;
        mr_status[`FLAN_ST_RF] = q.rf_status;
        mr_status[`FLAN_ST_AN_DONE] = q.an_complete;
        mr_expansion = 16'h0000;
        mr_expansion[`FLAN_EXP_PAGE_RX] = q.page_rx;
        mr_expansion[`FLAN_EXP_NXT_ABLE] = NXT_ABLE;
        mr_ext_status = 16'h0000;
        mr_ext_status[`FLAN_EXT_X_FD] = POSSESS_MASK[`FLAN_BIT_FD];
        mr_ext_status[`FLAN_EXT_X_HD] = POSSESS_MASK[`FLAN_BIT_HD];
    end

    assign mr_partner_base = q.lp_base;
    assign mr_partner_nxt = q.lp_nxt;
    assign mr_nxt_tx = q.nxt_tx;
    assign tx_cfg_word = q.tx_word;
    assign tx_send_cfg = q.send_cfg;
    assign resolved = q.res;
endmodule

`default_nettype wire

// ==== verilog/flan_defs.svh ====
// Constants for the fibre link auto-negotiation block: bit positions,
// masks, codes and timer figures.
// Assumes a 16-bit configuration word as carried by the coding sublayer.
`ifndef FLAN_DEFS_SVH
`define FLAN_DEFS_SVH

// Base page bit positions
`define FLAN_BIT_FD 5
`define FLAN_BIT_HD 6
`define FLAN_BIT_PS1 7
`define FLAN_BIT_PS2 8
`define FLAN_BIT_RF_LO 12
`define FLAN_BIT_ACK 14
`define FLAN_BIT_NXT 15
// Next page bit positions
`define FLAN_BIT_TGL 11
`define FLAN_BIT_ACK_SEC 12
`define FLAN_BIT_MSG 13
// Ability bits software may advertise (next page, both pause, both duplex)
`define FLAN_ABIL_MASK 16'h81e0
// Remote fault codes
`define FLAN_RF_NONE 2'h0
`define FLAN_RF_OFFLINE 2'h1
`define FLAN_RF_LINK_FAIL 2'h2
`define FLAN_RF_AN_ERROR 2'h3
// Message codes
`define FLAN_MSG_NULL 11'h001
`define FLAN_MSG_MAX 11'h00a
// Status, expansion and extended status bit positions
`define FLAN_ST_EXT_CAP 0
`define FLAN_ST_LINK 2
`define FLAN_ST_AN_ABLE 3
`define FLAN_ST_RF 4
`define FLAN_ST_AN_DONE 5
`define FLAN_EXP_PAGE_RX 1
`define FLAN_EXP_NXT_ABLE 2
`define FLAN_EXT_X_FD 15
`define FLAN_EXT_X_HD 14
// Settle timer: 10 ms at 100 MHz
`define FLAN_LINK_TIMER_MS 10
`define FLAN_CLK_KHZ 100000

`endif

// ==== verilog/flan_pkg.sv ====
// Types shared by the auto-negotiation core and its timer.
// Assumes flan_defs.svh supplies the numeric constants.
`default_nettype none

package flan_pkg;

    // Negotiation states
    typedef enum logic [2:0] {
        FLAN_AN_ENABLE = 3'b000,
        FLAN_AN_RESTART = 3'b001,
        FLAN_ABIL_DETECT = 3'b010,
        FLAN_ACK_DETECT = 3'b011,
        FLAN_COMPLETE_ACK = 3'b100,
        FLAN_IDLE_DETECT = 3'b101,
        FLAN_LINK_OK = 3'b110,
        FLAN_NXT_WAIT = 3'b111
    } flan_state_t;

    // Resolved link mode
    typedef struct packed {
        logic full_duplex;
        logic half_duplex;
        logic tx_pause;
        logic rx_pause;
        logic fail;
    } flan_res_t;

    // Timer state
    typedef struct packed {
        logic run;
        logic done;
        logic [31:0] cnt;
    } flan_tmr_t;

    // Core state
    typedef struct packed {
        flan_state_t state;
        logic [15:0] tx_word;
        logic send_cfg;
        logic [15:0] page_word;
        logic [15:0] base_word;
        logic [15:0] last_rx;
        logic [1:0] cnt;
        logic [1:0] idle_cnt;
        logic [15:0] abil_word;
        logic [1:0] rf_hold;
        logic rf_status;
        logic page_rx;
        logic [15:0] lp_base;
        logic [15:0] lp_nxt;
        logic [15:0] nxt_tx;
        logic nxt_tx_valid;
        logic nxt_phase;
        logic lp_more;
        logic tgl;
        logic an_en_prev;
        logic an_complete;
        flan_res_t res;
    } flan_core_t;

endpackage

`default_nettype wire

// ==== verilog/flan_timer.sv ====
// Settle timer: one-shot down counter, restarted by a start pulse.
// Assumes start is a one-cycle pulse on clk.
`default_nettype none

module flan_timer #(
    parameter int CYCLES = 1000000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    output logic done
);
    flan_pkg::flan_tmr_t q; // Registered state
    flan_pkg::flan_tmr_t d; // Next state

    // Next-state: load, count down, flag expiry
    always_comb
    begin
        d = q;
        if (start)
        begin
            // Start restarts even a running count
            d.run = 1'b1;
            d.done = 1'b0;
            d.cnt = 32'(CYCLES - 1);
        end
        else if (q.run)
        begin
            if (q.cnt == 32'h0)
            begin
                d.run = 1'b0;
                d.done = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt - 32'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= d;
    end

    assign done = q.done; // Level until next start
endmodule

`default_nettype wire
